// File: common/flwc_pkg.sv
// package for the fault latch and wake control block
// assumes a single 25 MHz clock and no software register access
package flwc_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40; // 25 MHz
  localparam int OE_LOW_US = 1000; // 1 ms
  localparam int OE_LOW_CYC = (OE_LOW_US * 1000 + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS; // least time, rounded up
  localparam int WAKE_SETUP_US = 10; // low setup time, plain default
  localparam int WAKE_SETUP_CYC = (WAKE_SETUP_US * 1000 +
    CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWRUP_US = 100; // regulator stage length, plain default
  localparam int PWRUP_CYC = (PWRUP_US * 1000 + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int GATE_OFF_NS = 100; // gate drive off bound
  localparam int GATE_OFF_CYC = GATE_OFF_NS / CLK_PERIOD_NS; // 2
  localparam int CNT_W = 16;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FLWC_POR, FLWC_REG, FLWC_ACTIVE, FLWC_STANDBY, FLWC_SLEEP
  } flwc_state_t;

  // power enables grouped together
  typedef struct packed {
    logic logic_supply_regulator; // logic supply regulator enable
    logic gate_drive_supply; // gate drive supply enable
    logic pump_feed; // 1: gate supply fed from pump
    logic amp_en; // amplifier enable
  } flwc_pwr_t;
  localparam flwc_pwr_t PWR_RESET = '{1'b0, 1'b0, 1'b0, 1'b1};
endpackage

// File: design/flwc_top.sv
// fault latch, power-up hold, wake detect and supply gating
// assumes asynchronous pins are synchronised here; faults are levels
`timescale 1ns/10ps
module flwc_top
  import flwc_pkg::*;
#(
  parameter int OE_LOW_COUNT = OE_LOW_CYC
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic oe_i, // output enable pin
  input wire logic wake_i, // resume pin
  input wire logic fault_cond_i, // any hardware fault active
  input wire logic amplifier_standby_disable_i, // config bit
  input wire logic sleep_cfg_i, // sleep enable config bit
  input wire logic pump_active_i, // charge pump running
  input wire logic [5:0] gate_cmd_i, // pwm gate commands
  output logic fault_n_o, // fault pin drive value (always low)
  output logic fault_oe_n_o, // low while pin is pulled low
  output logic [5:0] gate_o, // gate drive outputs
  output flwc_pwr_t pwr_o, // supply and amplifier enables
  output flwc_state_t state_o // current mode
);
  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic [1:0] oe_s; // oe sync stages
  logic [1:0] wk_s; // wake sync stages
  logic [1:0] fc_s; // fault sync stages
  logic [1:0][5:0] gc_s; // gate command sync stages, pwm pins
  logic oe_d; // delayed synced oe for edge detect
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oe_s <= 2'h0;
      wk_s <= 2'h0;
      fc_s <= 2'h0;
      gc_s <= '0;
      oe_d <= 1'b0;
    end else begin
      oe_s <= {oe_s[0], oe_i};
      wk_s <= {wk_s[0], wake_i};
      fc_s <= {fc_s[0], fault_cond_i};
      gc_s <= {gc_s[0], gate_cmd_i};
      oe_d <= oe_s[1];
    end
  end
  logic oe_rise;
  assign oe_rise = oe_s[1] && !oe_d;

  // ---------------------------------------------------------------
  // state machine and counters
  // ---------------------------------------------------------------
  flwc_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt; // power-up / oe low counter
  logic [CNT_W-1:0] wcnt, next_wcnt; // wake low counter
  logic armed, next_armed; // wake edge detector armed
  logic wk_d, next_wk_d; // delayed wake for edge detect
  logic latch, next_latch; // internal fault latch
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_wcnt = wcnt;
    next_armed = armed;
    next_wk_d = wk_s[1];
    // fault latch: set wins over clear
    if (fc_s[1]) begin
      next_latch = 1'b1;
    end else if (oe_rise) begin
      next_latch = 1'b0;
    end else begin
      next_latch = latch;
    end
    case (state)
      FLWC_POR: begin
        next_cnt = '0;
        next_state = FLWC_REG;
      end
      FLWC_REG: begin
        // regulator stage; fault pin held low meanwhile
        if (cnt >= CNT_W'(PWRUP_CYC - 1)) begin
          next_cnt = '0;
          next_state = FLWC_ACTIVE;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      FLWC_ACTIVE, FLWC_STANDBY: begin
        // short toggles for fault clear do not change mode
        if (oe_s[1]) begin
          next_cnt = '0;
          next_state = FLWC_ACTIVE;
        end else if (state == FLWC_ACTIVE) begin
          if (cnt >= CNT_W'(OE_LOW_COUNT - 1)) begin
            next_cnt = '0;
            next_wcnt = '0;
            next_armed = 1'b0;
            next_state = sleep_cfg_i ? FLWC_SLEEP
                                     : FLWC_STANDBY;
          end else begin
            next_cnt = cnt + 1'b1;
          end
        end
      end
      FLWC_SLEEP: begin
        // count continuous low time, then arm the edge detector
        if (wk_s[1]) begin
          next_wcnt = '0;
        end else if (wcnt >= CNT_W'(WAKE_SETUP_CYC - 1)) begin
          next_armed = 1'b1;
        end else begin
          next_wcnt = wcnt + 1'b1;
        end
        if (armed && wk_s[1] && !wk_d) begin
          next_armed = 1'b0;
          next_cnt = '0;
          next_state = FLWC_REG;
        end
      end
      default: next_state = FLWC_POR;
    endcase
  end

  // ---------------------------------------------------------------
  // output shaping
  // ---------------------------------------------------------------
  logic next_fault_oe_n;
  logic [5:0] next_gate;
  flwc_pwr_t next_pwr;
  always_comb begin
    // pin pulled low during power-up stage or while latched
    next_fault_oe_n = !(next_latch || next_state == FLWC_POR ||
                        next_state == FLWC_REG);
    // gates follow commands only when active and oe high; the off path
    // costs two sync stages plus this register, the sync cannot go
    next_gate = (oe_s[1] && state == FLWC_ACTIVE) ? gc_s[1]
                                                 : 6'h00;
    next_pwr.logic_supply_regulator = (next_state != FLWC_SLEEP);
    next_pwr.gate_drive_supply = (next_state == FLWC_ACTIVE);
    next_pwr.pump_feed = pump_active_i;
    next_pwr.amp_en = oe_s[1] || !amplifier_standby_disable_i;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= FLWC_POR;
      cnt <= '0;
      wcnt <= '0;
      armed <= 1'b0;
      wk_d <= 1'b0;
      latch <= 1'b0;
      fault_oe_n_o <= 1'b0;
      gate_o <= 6'h00;
      pwr_o <= PWR_RESET;
      state_o <= FLWC_POR;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      wcnt <= next_wcnt;
      armed <= next_armed;
      wk_d <= next_wk_d;
      latch <= next_latch;
      fault_oe_n_o <= next_fault_oe_n;
      gate_o <= next_gate;
      pwr_o <= next_pwr;
      state_o <= next_state;
    end
  end

  // open-drain pin only ever pulls low
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fault_n_o <= 1'b0;
    end else begin
      fault_n_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  sequence oe_low_hold;
    !oe_s[1] [*2];
  endsequence

  fault_pin_low_a: assert property (fc_s[1] |=> !fault_oe_n_o)
    else $error("fault active but pin released");
  fault_hold_a: assert property (
    (latch && !oe_rise) |=> !fault_oe_n_o)
    else $error("fault released without enable rise");
  pwrup_hold_a: assert property (
    (state == FLWC_REG) |-> !fault_oe_n_o)
    else $error("fault released during power-up");
  amp_off_a: assert property (
    (!oe_s[1] && amplifier_standby_disable_i) |=> !pwr_o.amp_en)
    else $error("amplifiers left on in standby");
  wake_edge_a: assert property (
    (state == FLWC_SLEEP && !armed) |=> state != FLWC_REG)
    else $error("woke without setup low time");
  reg_sleep_a: assert property (
    (state == FLWC_SLEEP) |-> !pwr_o.logic_supply_regulator)
    else $error("logic supply regulator on in sleep");
  pump_feed_a: assert property (
    ##1 pwr_o.pump_feed == $past(pump_active_i))
    else $error("gate supply feed wrong");
  clear_gate_a: assert property (
    (fc_s[1] && oe_rise) |=> latch)
    else $error("latch cleared while fault present");
  oe_filter_a: assert property (
    (state == FLWC_ACTIVE && cnt < CNT_W'(OE_LOW_COUNT - 1))
      |=> state != FLWC_STANDBY && state != FLWC_SLEEP)
    else $error("mode change before low time");
  gate_off_a: assert property (oe_low_hold |=> gate_o == 6'h00)
    else $error("gate outputs not forced low");
  wake_go_a: assert property (
    (state == FLWC_SLEEP && armed && wk_s[1] && !wk_d)
      |=> state == FLWC_REG)
    else $error("armed wake edge ignored");
  wake_arm_a: assert property (
    (!armed && wcnt < CNT_W'(WAKE_SETUP_CYC - 1)) |=> !armed)
    else $error("wake armed before low time");
endmodule

// File: tb/flwc_host.sv
// host model: drives the enable and resume pins, watches the fault pin
// assumes a pull-up on the fault wire and a pull-down on resume
`timescale 1ns/10ps
module flwc_host (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic oe_req_i, // wanted enable level
  input wire logic wake_req_i, // wanted resume level
  input wire logic fault_n_i, // device drive value
  input wire logic fault_oe_n_i, // device enable, low drives
  output logic oe_o, // enable pin
  output logic wake_o, // resume pin
  output logic fault_pin_o, // resolved fault wire
  output logic ready_o // start-up seen finished
);
  // ------------------------------------------------
  // pin logic
  // ------------------------------------------------
  // pull-up holds the wire while the device lets go
  assign fault_pin_o = fault_oe_n_i ? 1'b1 : fault_n_i;
  // pins move just after the edge, as a port would
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oe_o <= 1'b0;
      wake_o <= 1'b0;
      ready_o <= 1'b0;
    end else begin
      oe_o <= oe_req_i;
      wake_o <= wake_req_i;
      // first release after power-up means ready
      if (fault_pin_o) begin
        ready_o <= 1'b1;
      end
    end
  end
endmodule

// File: tb/tb_top.sv
// self-checking bench for the fault latch and wake control block
// assumes flwc_pkg and the host model are compiled first
`timescale 1ns/10ps
module tb_top;
  import flwc_pkg::*;
  // ------------------------------------------------
  // signals
  // ------------------------------------------------
  localparam int OE_CNT = 20; // short standby delay keeps runs brief
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic oe_req = 1'b1; // enable stays high unless a test lowers it
  logic wake_req = 1'b0;
  logic fault_cond_i = 1'b0;
  logic amplifier_standby_disable_i = 1'b0;
  logic sleep_cfg_i = 1'b0;
  logic pump_active_i = 1'b0;
  logic [5:0] gate_cmd_i = 6'h00;
  logic gate_hold = 1'b0; // freezes the random gate command
  logic oe_i, wake_i, fault_n_o, fault_oe_n_o, pin, ready;
  logic [5:0] gate_o;
  flwc_pwr_t pwr_o;
  flwc_state_t state_o;
  integer seed = 92;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [10:0] q[$]; // kind in the top bits, value below
  event ev;
  always #20 mclk_i = ~mclk_i;
  flwc_top #(.OE_LOW_COUNT(OE_CNT)) i_flwc_top (.mclk_i, .nrst_i,
    .oe_i, .wake_i, .fault_cond_i, .amplifier_standby_disable_i,
    .sleep_cfg_i, .pump_active_i, .gate_cmd_i, .fault_n_o,
    .fault_oe_n_o, .gate_o, .pwr_o, .state_o);
  flwc_host i_flwc_host (.mclk_i, .nrst_i, .oe_req_i(oe_req),
    .wake_req_i(wake_req), .fault_n_i(fault_n_o),
    .fault_oe_n_i(fault_oe_n_o), .oe_o(oe_i), .wake_o(wake_i),
    .fault_pin_o(pin), .ready_o(ready));
  // random gate commands so zeroed gates mean something
  always @(posedge mclk_i) begin
    if (!gate_hold) begin
      gate_cmd_i <= 6'($random(seed));
    end
  end
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // notes land at the falling edge, once outputs settled
  task automatic note(input logic [2:0] k, input logic [7:0] v);
    @(negedge mclk_i);
    q.push_back({k, v});
    ->ev;
  endtask
  task automatic cmp(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watcher: oldest note against what the outputs show now
  initial begin
    logic [10:0] n;
    forever begin
      @(ev);
      while (q.size() > 0) begin
        n = q.pop_front();
        case (n[10:8])
          3'h0: cmp("fault pin", n[7:0], {7'h00, pin});
          3'h1: cmp("state", n[7:0], {5'h00, state_o});
          3'h2: cmp("gates", n[7:0], {2'h0, gate_o});
          3'h3: cmp("supplies", n[7:0], {4'h0, pwr_o});
          3'h4: cmp("ready", n[7:0], {7'h00, ready});
          3'h5: cmp("amps", n[7:0], {7'h00, pwr_o.amp_en});
          default: cmp("regulator", n[7:0],
                       {7'h00, pwr_o.logic_supply_regulator});
        endcase
      end
    end
  end
  // hang guard, well above the expected run length
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 9000) begin
      n_fail++;
      test_done();
    end
  end
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    cyc(8);
    nrst_i <= 1'b1;
    cyc(100);
    note(3'h0, 8'h00);
    note(3'h1, 8'(FLWC_REG));
    note(3'h4, 8'h00);
    cyc(2500);
    note(3'h0, 8'h01);
    note(3'h4, 8'h01);
    note(3'h3, 8'h0d);
    cyc(1);
    gate_hold <= 1'b1;
    cyc(4);
    note(3'h2, {2'h0, gate_cmd_i});
    cyc(1);
    pump_active_i <= 1'b1;
    gate_hold <= 1'b0;
    cyc(6);
    note(3'h3, 8'h0f);
    cyc(1);
    pump_active_i <= 1'b0;
    amplifier_standby_disable_i <= 1'b1;
    fault_cond_i <= 1'b1;
    cyc(5);
    note(3'h0, 8'h00);
    cyc(1);
    oe_req <= 1'b0;
    cyc(5);
    note(3'h2, 8'h00);
    note(3'h5, 8'h00);
    cyc(1);
    oe_req <= 1'b1;
    cyc(10);
    note(3'h0, 8'h00);
    cyc(1);
    fault_cond_i <= 1'b0;
    cyc(10);
    note(3'h0, 8'h00);
    note(3'h5, 8'h01);
    cyc(1);
    oe_req <= 1'b0;
    cyc(5);
    oe_req <= 1'b1;
    cyc(10);
    note(3'h0, 8'h01);
    note(3'h1, 8'(FLWC_ACTIVE));
    cyc(1);
    oe_req <= 1'b0;
    cyc(18);
    note(3'h1, 8'(FLWC_ACTIVE));
    cyc(11);
    note(3'h1, 8'(FLWC_STANDBY));
    note(3'h3, 8'h08);
    cyc(1);
    amplifier_standby_disable_i <= 1'b0;
    cyc(5);
    note(3'h3, 8'h09);
    cyc(1);
    oe_req <= 1'b1;
    cyc(2600);
    note(3'h1, 8'(FLWC_ACTIVE));
    cyc(1);
    sleep_cfg_i <= 1'b1;
    wake_req <= 1'b1;
    oe_req <= 1'b0;
    cyc(30);
    note(3'h1, 8'(FLWC_SLEEP));
    note(3'h6, 8'h00);
    cyc(1);
    wake_req <= 1'b0;
    cyc(100);
    wake_req <= 1'b1;
    cyc(10);
    note(3'h1, 8'(FLWC_SLEEP));
    cyc(1);
    wake_req <= 1'b0;
    cyc(300);
    wake_req <= 1'b1;
    cyc(8);
    note(3'h1, 8'(FLWC_REG));
    note(3'h6, 8'h01);
    cyc(1);
    test_done();
  end
endmodule
